// ### tb/shared_pin_function_select_tb.sv
// shared_pin_function_select_tb.sv: directed tests of the shared pin selector
// assumes the design, its package and the board model are compiled first
`timescale 1ns/1ns
`default_nettype none
module shared_pin_function_select_tb
	import spf_pkg::*;
;
	logic mclk = 1'b0, rst = 1'b1, cpu_clock_en = 1'b0, timer_two_compare_out = 1'b0;
	logic ext_int_one_control = 1'b0, ext_int_two_control = 1'b0;
	logic converter_control_two = 1'b0, capture_control = 1'b0;
	logic compare_out_five = 1'b0, compare_out_six = 1'b0;
	spf_mpc_t master_pin_control = 16'h0000;
	spf_gpio_s port_a_bit5_cfg = 2'h0, port_a_bit6_cfg = 2'h0;
	spf_gpio_s port_a_bit7_cfg = 2'h0, port_b_bit0_cfg = 2'h0;
	logic [3:0] xen = 4'h0, xv = 4'h0;
	logic pin_a5_i, pin_a6_i, pin_b0_i, pin_a7_i;
	spf_pin_drv_s pin_a5_drv, pin_a6_drv, pin_b0_drv, pin_a7_drv;
	logic port_a_bit5, port_a_bit6, port_a_bit7, port_b_bit0;
	logic ext_interrupt_one, ext_interrupt_two, conversion_start_input, capture_one_input;
	int fails = 0, check_count = 0;
	spf_pin_select uut (.*);
	spf_board b5 (.drv(pin_a5_drv), .ext_en(xen[0]), .ext_val(xv[0]), .pin(pin_a5_i));
	spf_board b6 (.drv(pin_a6_drv), .ext_en(xen[1]), .ext_val(xv[1]), .pin(pin_a6_i));
	spf_board b0 (.drv(pin_b0_drv), .ext_en(xen[2]), .ext_val(xv[2]), .pin(pin_b0_i));
	spf_board b7 (.drv(pin_a7_drv), .ext_en(xen[3]), .ext_val(xv[3]), .pin(pin_a7_i));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		tk(20);
		rst = 1'b0;
		tk(4);
		chk("b0 drv", 3'h0, pin_b0_drv);
		chk("int one", 3'h1, ext_interrupt_one);
		$display("test reset done");
		port_b_bit0_cfg = 2'h3;
		ext_int_one_control = 1'b1;
		tk(1);
		chk("b0 drv", 3'h3, pin_b0_drv);
		port_b_bit0_cfg = 2'h0;
		xen[2] = 1'b1;
		tk(5);
		chk("b0 oe", 3'h0, pin_b0_drv.oe);
		chk("int one", 3'h0, ext_interrupt_one);
		chk("b0 port", 3'h0, port_b_bit0);
		$display("test gpio done");
		xen[2] = 1'b0;
		port_b_bit0_cfg = 2'h3;
		master_pin_control = 16'h0100;
		tk(1);
		chk("b0 drv", 3'h1, pin_b0_drv);
		tk(4);
		chk("int one", 3'h0, ext_interrupt_one);
		timer_two_compare_out = 1'b1;
		ext_int_one_control = 1'b0;
		tk(5);
		chk("b0 drv", 3'h3, pin_b0_drv);
		chk("int one", 3'h1, ext_interrupt_one);
		$display("test timer done");
		master_pin_control = 16'h0000;
		xen[3] = 1'b1;
		for (int k = 0; k < 3; k++) begin
			{ext_int_two_control, converter_control_two, capture_control} = 3'h4 >> k;
			tk(5);
			chk("a7 inputs", ~(3'h4 >> k),
				{ext_interrupt_two, conversion_start_input, capture_one_input});
			chk("a7 port", 3'h0, port_a_bit7);
		end
		{ext_int_two_control, converter_control_two, capture_control} = 3'h7;
		master_pin_control = 16'h0080;
		cpu_clock_en = 1'b1;
		tk(1);
		cpu_clock_en = 1'b0;
		tk(1);
		chk("a7 drv", 3'h3, pin_a7_drv);
		tk(4);
		chk("a7 inputs", 3'h7,
			{ext_interrupt_two, conversion_start_input, capture_one_input});
		chk("a7 port", 3'h1, port_a_bit7);
		$display("test five function done");
		master_pin_control = 16'h0060;
		compare_out_five = 1'b1;
		port_a_bit5_cfg = 2'h1;
		port_a_bit6_cfg = 2'h3;
		tk(1);
		chk("a5 drv", 3'h3, pin_a5_drv);
		chk("a6 drv", 3'h1, pin_a6_drv);
		master_pin_control = 16'h0000;
		tk(1);
		chk("a5 drv", 3'h1, pin_a5_drv);
		chk("a6 drv", 3'h3, pin_a6_drv);
		tk(3);
		chk("a5 port", 3'h0, port_a_bit5);
		chk("a6 port", 3'h1, port_a_bit6);
		$display("test compare pins done");
		tally_and_finish();
	end
	// bound well above the directed sequence length
	initial begin
		tk(500);
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ### tb/spf_board.sv
// spf_board.sv: board side of one shared pin with the internal pull-up
// assumes the device driver wins over the board when both drive
`timescale 1ns/1ns
`default_nettype none
module spf_board
	import spf_pkg::*;
(
	input wire spf_pin_drv_s drv,
	input wire logic ext_en,
	input wire logic ext_val,
	output logic pin
);
	// released pin floats up to the pull-up level
	assign pin = drv.oe ? drv.o : (ext_en ? ext_val : 1'b1);
endmodule
`default_nettype wire

// ### tb/spf_pin_select_properties.sv
// spf_pin_select_properties.sv: port-level checks for the shared pin selector
// assumes one mclk domain with synchronous active-high rst
`timescale 1ns/1ns
`default_nettype none
module spf_pin_select_properties
	import spf_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire spf_mpc_t master_pin_control,
	input wire logic ext_int_one_control,
	input wire logic ext_int_two_control,
	input wire logic converter_control_two,
	input wire logic capture_control,
	input wire spf_gpio_s port_b_bit0_cfg,
	input wire logic timer_two_compare_out,
	input wire logic pin_b0_i,
	input wire logic pin_a7_i,
	input wire spf_pin_drv_s pin_b0_drv,
	input wire spf_pin_drv_s pin_a7_drv,
	input wire logic ext_interrupt_one,
	input wire logic ext_interrupt_two,
	input wire logic conversion_start_input,
	input wire logic capture_one_input
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_reset_no_drive: assert property ($fell(rst) |-> pin_b0_drv == 2'h0)
		else $error("timer pin driven after reset");
	chk_b0_timer_out: assert property (master_pin_control[8] |=>
		pin_b0_drv == {$past(timer_two_compare_out), 1'b1})
		else $error("timer compare not on pin");
	chk_b0_gpio_dir: assert property (!master_pin_control[8] |=>
		pin_b0_drv.oe == $past(port_b_bit0_cfg.dir))
		else $error("port direction not honoured");
	chk_a7_clock_drive: assert property (master_pin_control[7] |=> pin_a7_drv.oe)
		else $error("clock output not driven");
	chk_a7_held_high: assert property (master_pin_control[7] [*4] |->
		ext_interrupt_two && conversion_start_input && capture_one_input)
		else $error("peripheral input not held high");
	chk_int_one_idle: assert property (!ext_int_one_control [*4] |-> ext_interrupt_one)
		else $error("interrupt one active while disabled");
	chk_int_one_pin: assert property (ext_int_one_control [*4] |->
		ext_interrupt_one == $past(pin_b0_i, 3))
		else $error("interrupt one not following pin");
	chk_int_two_pin: assert property ((ext_int_two_control && !master_pin_control[7]) [*4]
		|-> ext_interrupt_two == $past(pin_a7_i, 3))
		else $error("interrupt two not following pin");
	chk_conv_idle: assert property (!converter_control_two [*4] |-> conversion_start_input)
		else $error("conversion start active while disabled");
	chk_cap_idle: assert property (!capture_control [*4] |-> capture_one_input)
		else $error("capture input active while disabled");
endmodule
bind spf_pin_select spf_pin_select_properties chk (.*);
`default_nettype wire

// ### verilog/spf_consts.svh
// spf_consts.svh: bit positions and reset values for the shared pin selector
// assumes it is included by bare name from the package and the design file
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH
// ------------------------------------------------------------
// master pin control bit positions
// ------------------------------------------------------------
`define SPF_MPC_WIDTH 16
`define SPF_MPC_CPU_CLOCK_OUTPUT_BIT 7
`define SPF_MPC_T2CMP_BIT 8
`define SPF_MPC_CMP5_BIT 5
`define SPF_MPC_CMP6_BIT 6
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SPF_MPC_RESET 16'h0000
`define SPF_PIN_OE_RESET 1'b0
`endif

// ### verilog/spf_pin_select.sv
// spf_pin_select.sv: function select for four shared device pins
// assumes pins are resolved outside from o/oe pairs; peripheral enables and
// port data/direction come from registers on mclk
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "spf_consts.svh"
module spf_pin_select
	import spf_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	// master pin control as written by software
	input wire logic [`SPF_MPC_WIDTH-1:0] master_pin_control,
	// peripheral enable bits from the respective control registers
	input wire logic ext_int_one_control,
	input wire logic ext_int_two_control,
	input wire logic converter_control_two,
	input wire logic capture_control,
	// port data/direction bits
	input wire spf_gpio_s port_a_bit5_cfg,
	input wire spf_gpio_s port_a_bit6_cfg,
	input wire spf_gpio_s port_a_bit7_cfg,
	input wire spf_gpio_s port_b_bit0_cfg,
	// peripheral output sources
	input wire logic compare_out_five,
	input wire logic compare_out_six,
	input wire logic timer_two_compare_out,
	input wire logic cpu_clock_en,
	// raw pin levels
	input wire logic pin_a5_i,
	input wire logic pin_a6_i,
	input wire logic pin_b0_i,
	input wire logic pin_a7_i,
	// pin drivers
	output spf_pin_drv_s pin_a5_drv,
	output spf_pin_drv_s pin_a6_drv,
	output spf_pin_drv_s pin_b0_drv,
	output spf_pin_drv_s pin_a7_drv,
	// synchronised levels to the port data registers
	output logic port_a_bit5,
	output logic port_a_bit6,
	output logic port_a_bit7,
	output logic port_b_bit0,
	// inputs to the peripherals
	output logic ext_interrupt_one,
	output logic ext_interrupt_two,
	output logic conversion_start_input,
	output logic capture_one_input
);
	localparam int NPIN = 4;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// pin levels are asynchronous; two flops before any mux looks at them
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1_q;
	logic [NPIN-1:0] sync1_d;
	logic [NPIN-1:0] sync2_q;
	logic [NPIN-1:0] sync2_d;

	assign pin_raw = {pin_a7_i, pin_b0_i, pin_a6_i, pin_a5_i};

	always_comb begin
		sync1_d = pin_raw;
		sync2_d = sync1_q;
	end

	// pull-ups hold the idle level high, so reset to ones
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= '1;
			sync2_q <= '1;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ------------------------------------------------------------
	// cpu clock output
	// ------------------------------------------------------------
	// the cpu clock is represented as a toggle on each enable pulse so the
	// pad sees a registered square wave rather than a gated clock
	logic clk_out_q;
	logic clk_out_d;

	always_comb begin
		clk_out_d = clk_out_q;
		if (cpu_clock_en)
			clk_out_d = ~clk_out_q;
	end

	// the toggle runs whether or not the pin shows it, so selecting the
	// clock output never waits for a first pulse
	always_ff @(posedge mclk) begin
		if (rst)
			clk_out_q <= 1'b0;
		else
			clk_out_q <= clk_out_d;
	end

	// ------------------------------------------------------------
	// select and drive
	// ------------------------------------------------------------
	logic sel_cmp5;
	logic sel_cmp6;
	logic sel_t2;
	logic sel_clk;

	assign sel_cmp5 = master_pin_control[`SPF_MPC_CMP5_BIT];
	assign sel_cmp6 = master_pin_control[`SPF_MPC_CMP6_BIT];
	assign sel_t2 = master_pin_control[`SPF_MPC_T2CMP_BIT];
	assign sel_clk = master_pin_control[`SPF_MPC_CPU_CLOCK_OUTPUT_BIT];

	spf_pin_drv_s a5_d;
	spf_pin_drv_s a6_d;
	spf_pin_drv_s b0_d;
	spf_pin_drv_s a7_d;
	spf_pin_drv_s a5_q;
	spf_pin_drv_s a6_q;
	spf_pin_drv_s b0_q;
	spf_pin_drv_s a7_q;

	always_comb begin
		// port bits: input unless direction bit asks for an output
		a5_d.o = port_a_bit5_cfg.dat;
		a5_d.oe = port_a_bit5_cfg.dir;
		a6_d.o = port_a_bit6_cfg.dat;
		a6_d.oe = port_a_bit6_cfg.dir;
		b0_d.o = port_b_bit0_cfg.dat;
		b0_d.oe = port_b_bit0_cfg.dir;
		a7_d.o = port_a_bit7_cfg.dat;
		a7_d.oe = port_a_bit7_cfg.dir;
		if (sel_cmp5) begin
			a5_d.o = compare_out_five;
			a5_d.oe = 1'b1;
		end
		if (sel_cmp6) begin
			a6_d.o = compare_out_six;
			a6_d.oe = 1'b1;
		end
		if (sel_t2) begin
			b0_d.o = timer_two_compare_out;
			b0_d.oe = 1'b1;
		end
		if (sel_clk) begin
			a7_d.o = clk_out_d;
			a7_d.oe = 1'b1;
		end
	end

	// master control resets to zero upstream, so the timer pin comes up as
	// interrupt/port input; the driver flops also clear here
	always_ff @(posedge mclk) begin
		if (rst) begin
			a5_q <= '{o: 1'b0, oe: `SPF_PIN_OE_RESET};
			a6_q <= '{o: 1'b0, oe: `SPF_PIN_OE_RESET};
			b0_q <= '{o: 1'b0, oe: `SPF_PIN_OE_RESET};
			a7_q <= '{o: 1'b0, oe: `SPF_PIN_OE_RESET};
		end else begin
			a5_q <= a5_d;
			a6_q <= a6_d;
			b0_q <= b0_d;
			a7_q <= a7_d;
		end
	end

	assign pin_a5_drv = a5_q;
	assign pin_a6_drv = a6_q;
	assign pin_b0_drv = b0_q;
	assign pin_a7_drv = a7_q;

	// ------------------------------------------------------------
	// input routing to port and peripherals
	// ------------------------------------------------------------
	// peripheral inputs idle high when not enabled, matching the pull-up,
	// so no spurious edge reaches an edge-sensitive peripheral
	logic [7:0] in_d;
	logic [7:0] in_q;
	logic a7_seen;

	always_comb begin
		// clock output masks the pin from the three input peripherals
		a7_seen = sel_clk ? 1'b1 : sync2_q[3];
		in_d[0] = sync2_q[0];
		in_d[1] = sync2_q[1];
		in_d[2] = sync2_q[3];
		in_d[3] = sync2_q[2];
		// interrupt one ignores the timer compare select entirely
		in_d[4] = ext_int_one_control ? sync2_q[2] : 1'b1;
		// each function gated by its own peripheral enable and masked by sel_clk; no arbiter
		in_d[5] = ext_int_two_control ? a7_seen : 1'b1;
		in_d[6] = converter_control_two ? a7_seen : 1'b1;
		in_d[7] = capture_control ? a7_seen : 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			in_q <= 8'hff;
		else
			in_q <= in_d;
	end

	assign port_a_bit5 = in_q[0];
	assign port_a_bit6 = in_q[1];
	assign port_a_bit7 = in_q[2];
	assign port_b_bit0 = in_q[3];
	assign ext_interrupt_one = in_q[4];
	assign ext_interrupt_two = in_q[5];
	assign conversion_start_input = in_q[6];
	assign capture_one_input = in_q[7];
endmodule
`default_nettype wire

// ### verilog/spf_pkg.sv
// spf_pkg.sv: types shared by the shared pin selector
// assumes spf_consts.svh is on the include path
`default_nettype none
`include "spf_consts.svh"
package spf_pkg;
	typedef logic [`SPF_MPC_WIDTH-1:0] spf_mpc_t;

	// one bidirectional pin as driven by the design: out, enable
	typedef struct packed {
		logic o;
		logic oe;
	} spf_pin_drv_s;

	// per-pin port data/direction bits from the general-purpose port block
	typedef struct packed {
		logic dat;
		logic dir;
	} spf_gpio_s;

	// peripheral enables that claim the five-function pin as an input
	typedef struct packed {
		logic int_two_en;
		logic conv_start_en;
		logic capture_en;
	} spf_in_en_s;
endpackage
`default_nettype wire
